/* src/qwp_dev.sv */
// memory-side protection command logic: decodes frames, keeps quadrant flags
// Operation
// - set command is 0110, selector, write bit
// - set acts only with elevated lsb pin
// - set protects only the selected quadrant
// - only clear unprotects, always all four
// - set selectors 001,100,101,000 map quadrants 0-3
// - clear control byte 66h is acknowledged
// - clear address and data bytes are acknowledged
// - clear needs elevated lsb pin whole frame
// - host ends clear with a stop
// - query is set byte with read bit
// - query accepted at any lsb level
// - query acks if unprotected, nacks if protected
// - query address and data bytes always nacked
// - host ends query with a stop
// - query selectors decode like set selectors
// - upper select pins ignored by commands
// - quadrant is page bit and address bit 7
//
// Local design decisions: the address map and the strobed register port.
`default_nettype none
module qwp_dev (
  input wire logic sys_clk,
  input wire logic reset,
  qwp_link_if.dev lif,
  input wire logic page_select_state,
  output logic [3:0] protect_flags,
  output logic prog_req,
  output logic [7:0] prog_addr,
  output logic [7:0] prog_data
);
  import qwp_pkg::*;

  typedef enum logic [3:0] {
    D_IDLE = 4'b0001,
    D_RX = 4'b0010,
    D_ACK = 4'b0100,
    D_IGN = 4'b1000
  } qwp_dstate_e;

  typedef enum logic [4:0] {
    M_NONE = 5'b00001,
    M_SET = 5'b00010,
    M_CLR = 5'b00100,
    M_QUERY = 5'b01000,
    M_WRITE = 5'b10000
  } qwp_mode_e;

  qwp_dstate_e state;
  qwp_mode_e mode;
  qwp_mode_e next_mode;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [1:0] byte_cnt;
  logic [1:0] sel_idx;
  logic [7:0] word_addr;
  logic [7:0] data_byte;
  logic hv_ok;
  logic sda_drive;
  logic [5:0] pin_q;
  logic [5:0] pin_prev;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and bus conditions

  qwp_sync #(.WIDTH(6)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in({lif.scl, lif.sda, lif.lsb_code, lif.mid, lif.msb}),
    .sync_q(pin_q),
    .sync_prev(pin_prev)
  );

  // decoded levels and edges, all from the second stage onward
  wire scl_s = pin_q[5];
  wire sda_s = pin_q[4];
  wire [1:0] lsb_s = pin_q[3:2];
  wire mid_s = pin_q[1];
  wire msb_s = pin_q[0];
  wire scl_p = pin_prev[5];
  wire sda_p = pin_prev[4];
  wire scl_rise = scl_s && !scl_p;
  wire scl_fall = !scl_s && scl_p;
  wire start_det = scl_s && scl_p && sda_p && !sda_s;
  wire stop_det = scl_s && scl_p && !sda_p && sda_s;
  wire hv_now = (lsb_s == PIN_HV);
  wire frame_on = (state != D_IDLE);
  wire byte_done = (state == D_RX) && scl_fall && (bit_cnt == 4'h8);
  wire ack_done = (state == D_ACK) && scl_fall;

  ////////////////////////////////////////////////////////////////////////////
  // control byte decode

  wire [2:0] sel_f = shift[SEL_LSB+2:SEL_LSB];
  wire [2:0] qdec = quad_of_sel(sel_f);
  wire q_valid = qdec[2];
  wire [1:0] q_idx = qdec[1:0];
  wire is_cmd = (shift[TYPE_LSB+3:TYPE_LSB] == CMD_TYPE);
  wire is_rd = shift[RW_BIT];
  wire lsb_bit = (lsb_s != PIN_LOW);
  // only ordinary frames compare the select pins; commands never look at mid/msb
  wire is_mem = (shift[TYPE_LSB+3:TYPE_LSB] == MEM_TYPE) && !is_rd &&
                (sel_f == {msb_s, mid_s, lsb_bit});
  wire hv_frame = hv_ok && hv_now;
  wire [1:0] wr_quad = {page_select_state, word_addr[7]};
  wire frame_full = (byte_cnt == FRAME_BYTES);

  // mode chosen from the control byte
  always_comb begin
    next_mode = M_NONE;
    if (is_cmd && is_rd && q_valid) begin
      next_mode = M_QUERY;
    end else if (is_cmd && !is_rd && hv_frame && q_valid) begin
      next_mode = M_SET;
    end else if (is_cmd && !is_rd && hv_frame && (sel_f == SEL_CLR)) begin
      next_mode = M_CLR;
    end else if (is_mem) begin
      next_mode = M_WRITE;
    end
  end

  // acknowledge decision for the byte just received
  wire ctrl_ack = (next_mode == M_SET) || (next_mode == M_CLR) || (next_mode == M_WRITE) ||
                  ((next_mode == M_QUERY) && !protect_flags[q_idx]);
  // later bytes: query never acks, commands and writes always do
  wire tail_ack = (mode == M_SET) || (mode == M_CLR) || (mode == M_WRITE);
  wire ack_now = (byte_cnt == 2'h0) ? ctrl_ack : tail_ack;

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  // start and stop win over bit activity; a repeated start restarts the frame
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= D_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      sda_drive <= 1'b0;
    end else if (start_det) begin
      state <= D_RX;
      bit_cnt <= 4'h0;
      sda_drive <= 1'b0;
    end else if (stop_det) begin
      state <= D_IDLE;
      sda_drive <= 1'b0;
    end else begin
      case (state)
        D_RX: begin
          if (scl_rise && (bit_cnt != 4'h8)) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            state <= D_ACK;
            sda_drive <= ack_now;
            bit_cnt <= 4'h0;
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            sda_drive <= 1'b0;
            state <= (mode == M_NONE) ? D_IGN : D_RX;
          end
        end
        D_IGN: state <= D_IGN;
        D_IDLE: state <= D_IDLE;
        default: state <= D_IDLE;
      endcase
    end
  end

  // frame bookkeeping: mode, byte count, captured fields, elevated level seen
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode <= M_NONE;
      byte_cnt <= 2'h0;
      sel_idx <= 2'h0;
      word_addr <= 8'h00;
      data_byte <= 8'h00;
      hv_ok <= 1'b0;
    end else if (start_det) begin
      mode <= M_NONE;
      byte_cnt <= 2'h0;
      hv_ok <= hv_now;
    end else begin
      if (frame_on && !hv_now) begin
        hv_ok <= 1'b0;
      end
      if (byte_done && (byte_cnt == 2'h0)) begin
        mode <= next_mode;
        sel_idx <= q_idx;
      end else if (byte_done && (byte_cnt == 2'h1)) begin
        word_addr <= shift;
      end else if (byte_done) begin
        data_byte <= shift; // page bursts keep the last byte only
      end
      if (ack_done && !frame_full) begin
        byte_cnt <= byte_cnt + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protection flags and programming requests, acted on at stop

  wire stop_full = stop_det && (state != D_IDLE) && frame_full && hv_frame;

  // flags move only on complete set or clear frames
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      protect_flags <= PROT_RESET;
    end else if (stop_full && (mode == M_SET)) begin
      protect_flags[sel_idx] <= 1'b1;
    end else if (stop_full && (mode == M_CLR)) begin
      protect_flags <= PROT_RESET;
    end
  end

  wire write_go = stop_det && (state != D_IDLE) && (mode == M_WRITE) && frame_full;

  // a protected target is acked on the bus but never reaches the programmer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prog_req <= 1'b0;
      prog_addr <= 8'h00;
      prog_data <= 8'h00;
    end else begin
      prog_req <= write_go && !protect_flags[wr_quad];
      if (write_go && !protect_flags[wr_quad]) begin
        prog_addr <= word_addr;
        prog_data <= data_byte;
      end
    end
  end

  // open drain: only ever pull low
  assign lif.dev_sda_o = 1'b0;
  assign lif.dev_sda_oe = sda_drive;
endmodule : qwp_dev
`default_nettype wire

/* pkg/qwp_pkg.sv */
// shared constants, encodings and helpers for the quadrant write protect link
`default_nettype none
package qwp_pkg;
  // control byte layout
  localparam logic [3:0] CMD_TYPE = 4'h6; // protection command type nibble
  localparam logic [3:0] MEM_TYPE = 4'hA; // ordinary memory type nibble, plain default
  localparam int TYPE_LSB = 4;
  localparam int SEL_LSB = 1;
  localparam int RW_BIT = 0;
  // quadrant_selector_field codes
  localparam logic [2:0] SEL_Q0 = 3'h1;
  localparam logic [2:0] SEL_Q1 = 3'h4;
  localparam logic [2:0] SEL_Q2 = 3'h5;
  localparam logic [2:0] SEL_Q3 = 3'h0;
  localparam logic [2:0] SEL_CLR = 3'h3;
  // level code on addr_select_pin_lsb
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_HIGH = 2'h1;
  localparam logic [1:0] PIN_HV = 2'h2; // elevated_pin_voltage
  // byte count after which a frame is complete (ctrl, addr, data)
  localparam logic [1:0] FRAME_BYTES = 2'h3;
  localparam logic [3:0] PROT_RESET = 4'h0;
  // host register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_XFER = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_QUAD_LSB = 2;
  localparam int CMD_HV_BIT = 4;
  localparam int XFER_DATA_LSB = 8;
  localparam int STAT_ACK_LSB = 1;
  localparam logic [1:0] KIND_SET = 2'h0;
  localparam logic [1:0] KIND_CLR = 2'h1;
  localparam logic [1:0] KIND_QUERY = 2'h2;
  localparam logic [1:0] KIND_WRITE = 2'h3;
  // timing
  localparam int CLK_KHZ = 50000;
  localparam int SCL_KHZ = 1000;
  localparam int QUARTER_CYC = CLK_KHZ / (SCL_KHZ * 4);

  // selector to {valid, quadrant}
  function automatic logic [2:0] quad_of_sel(input logic [2:0] sel);
    case (sel)
      SEL_Q0: quad_of_sel = 3'h4;
      SEL_Q1: quad_of_sel = 3'h5;
      SEL_Q2: quad_of_sel = 3'h6;
      SEL_Q3: quad_of_sel = 3'h7;
      default: quad_of_sel = 3'h0;
    endcase
  endfunction : quad_of_sel

  // quadrant to selector
  function automatic logic [2:0] sel_of_quad(input logic [1:0] quad);
    case (quad)
      2'h0: sel_of_quad = SEL_Q0;
      2'h1: sel_of_quad = SEL_Q1;
      2'h2: sel_of_quad = SEL_Q2;
      default: sel_of_quad = SEL_Q3;
    endcase
  endfunction : sel_of_quad
endpackage : qwp_pkg
`default_nettype wire

/* pkg/qwp_link_if.sv */
// two-wire link between host and protected memory, with resolved open-drain data
`default_nettype none
interface qwp_link_if;
  logic host_scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic [1:0] lsb_code;
  logic mid;
  logic msb;
  logic scl;
  logic sda;
  // wired-and: any enabled driver pulls low
  assign scl = host_scl;
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport host (output host_scl, output host_sda_o, output host_sda_oe,
                output lsb_code, output mid, output msb, input sda);
  modport dev (input scl, input sda, input lsb_code, input mid, input msb,
               output dev_sda_o, output dev_sda_oe);
endinterface : qwp_link_if
`default_nettype wire

/* src/qwp_sync.sv */
// two-flop synchroniser with one extra stage for edge finding
`default_nettype none
module qwp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_q,
  output logic [WIDTH-1:0] sync_prev
);
  logic [WIDTH-1:0] meta;

  // meta is read only by sync_q
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta <= '0;
      sync_q <= '0;
      sync_prev <= '0;
    end else begin
      meta <= async_in;
      sync_q <= meta;
      sync_prev <= sync_q;
    end
  end
endmodule : qwp_sync
`default_nettype wire

/* src/qwp_host.sv */
// host-side link controller: runs one three-byte frame per command register write made while idle
`default_nettype none
module qwp_host #(
  parameter logic STRAP_MID = 1'b0,
  parameter logic STRAP_MSB = 1'b0
) (
  input wire logic sys_clk,
  input wire logic reset,
  qwp_link_if.host lif,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import qwp_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_START = 4'b0010,
    H_BIT = 4'b0100,
    H_STOP = 4'b1000
  } qwp_hstate_e;

  localparam logic [7:0] Q_LAST = 8'(QUARTER_CYC - 1);

  qwp_hstate_e state;
  logic [1:0] cmd_kind;
  logic [1:0] cmd_quad;
  logic cmd_hv;
  logic [7:0] xfer_addr;
  logic [7:0] xfer_data;
  logic [2:0] acks;
  logic [7:0] qcnt;
  logic [1:0] qph;
  logic [3:0] bit_i;
  logic [1:0] byte_i;
  logic scl_out;
  logic sda_low;
  logic [1:0] lsb_code;
  logic sda_s;
  logic next_scl;
  logic next_sda;

  ////////////////////////////////////////////////////////////////////////////
  // register port

  wire busy = (state != H_IDLE);
  wire launch = reg_wr && (reg_addr == REG_CMD) && !busy; // busy writes are dropped
  wire q_end = (qcnt == Q_LAST);
  wire bit_end = q_end && (qph == 2'h3);

  // command and transfer registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cmd_kind <= KIND_SET;
      cmd_quad <= 2'h0;
      cmd_hv <= 1'b0;
      xfer_addr <= 8'h00;
      xfer_data <= 8'h00;
    end else if (launch) begin
      cmd_kind <= reg_wdata[CMD_KIND_LSB+1:CMD_KIND_LSB];
      cmd_quad <= reg_wdata[CMD_QUAD_LSB+1:CMD_QUAD_LSB];
      cmd_hv <= reg_wdata[CMD_HV_BIT];
    end else if (reg_wr && (reg_addr == REG_XFER) && !busy) begin
      xfer_addr <= reg_wdata[7:0];
      xfer_data <= reg_wdata[XFER_DATA_LSB+7:XFER_DATA_LSB];
    end
  end

  // read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && (reg_addr == REG_CMD)) begin
      reg_rdata <= {27'h0, cmd_hv, cmd_quad, cmd_kind};
    end else if (reg_rd && (reg_addr == REG_XFER)) begin
      reg_rdata <= {16'h0, xfer_data, xfer_addr};
    end else if (reg_rd && (reg_addr == REG_STATUS)) begin
      reg_rdata <= {28'h0, acks, busy};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte building

  wire [2:0] sel_w = (cmd_kind == KIND_CLR) ? SEL_CLR : sel_of_quad(cmd_quad);
  wire [7:0] ctrl_cmd = {CMD_TYPE, sel_w, (cmd_kind == KIND_QUERY)};
  wire [7:0] ctrl_mem = {MEM_TYPE, STRAP_MSB, STRAP_MID, cmd_hv, 1'b0};
  wire [7:0] ctrl_byte = (cmd_kind == KIND_WRITE) ? ctrl_mem : ctrl_cmd;
  wire [7:0] tx_byte = (byte_i == 2'h0) ? ctrl_byte :
                       (byte_i == 2'h1) ? xfer_addr : xfer_data;
  wire tx_bit = (bit_i == 4'h8) ? 1'b1 : tx_byte[3'(4'h7 - bit_i)];

  qwp_sync #(.WIDTH(1)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(lif.sda),
    .sync_q(sda_s),
    .sync_prev()
  );

  ////////////////////////////////////////////////////////////////////////////
  // bit sequencer: four quarters per bit, scl high in the last two

  // wanted line levels for the current quarter
  always_comb begin
    next_scl = 1'b1;
    next_sda = 1'b1;
    case (state)
      H_IDLE: next_sda = 1'b1;
      H_START: next_sda = (qph < 2'h2);
      H_BIT: begin
        next_scl = (qph >= 2'h2);
        next_sda = tx_bit;
      end
      H_STOP: begin
        next_scl = (qph >= 2'h2);
        next_sda = (qph == 2'h3);
      end
      default: next_sda = 1'b1;
    endcase
  end

  // quarter timer, bit and byte position, acknowledge capture
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= H_IDLE;
      qcnt <= 8'h00;
      qph <= 2'h0;
      bit_i <= 4'h0;
      byte_i <= 2'h0;
      acks <= 3'h0;
    end else if (launch) begin
      state <= H_START;
      qcnt <= 8'h00;
      qph <= 2'h0;
      acks <= 3'h0;
    end else if (busy) begin
      qcnt <= q_end ? 8'h00 : qcnt + 8'h01;
      qph <= q_end ? qph + 2'h1 : qph;
      if (bit_end) begin
        case (state)
          H_START: begin
            state <= H_BIT;
            bit_i <= 4'h0;
            byte_i <= 2'h0;
          end
          H_BIT: begin
            bit_i <= (bit_i == 4'h8) ? 4'h0 : bit_i + 4'h1;
            if (bit_i == 4'h8) begin
              acks[byte_i] <= !sda_s; // either answer is accepted after clear
              byte_i <= byte_i + 2'h1;
              state <= (byte_i == 2'h2) ? H_STOP : H_BIT;
            end
          end
          H_STOP: state <= H_IDLE;
          default: state <= H_IDLE;
        endcase
      end
    end
  end

  // pins from flops; the lsb level is held from before start until after stop
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_out <= 1'b1;
      sda_low <= 1'b0;
      lsb_code <= PIN_LOW;
    end else begin
      scl_out <= next_scl;
      sda_low <= !next_sda;
      if (launch) begin
        lsb_code <= reg_wdata[CMD_HV_BIT] ? PIN_HV : PIN_LOW;
      end else if (!busy) begin
        lsb_code <= PIN_LOW;
      end
    end
  end

  assign lif.host_scl = scl_out;
  assign lif.host_sda_o = 1'b0;
  assign lif.host_sda_oe = sda_low;
  assign lif.lsb_code = lsb_code;
  assign lif.mid = STRAP_MID;
  assign lif.msb = STRAP_MSB;
endmodule : qwp_host
`default_nettype wire

/* testbench/qwp_asserts.sv */
// concurrent checks on the host to memory protection link
`default_nettype none
module qwp_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic [1:0] lsb_code,
  input wire logic mid,
  input wire logic msb,
  input wire logic [3:0] protect_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  import qwp_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // both lines released: the only state in which a frame may end or begin
  sequence bus_idle;
    scl && sda;
  endsequence
  // an acknowledge is held for a solid run before it is let go
  sequence ack_held;
    dev_sda_oe [*8];
  endsequence
  ////////////////////////////////////////
  flag_needs_hv_a: assert property (
    $changed(protect_flags) |-> $past(lsb_code, 2) == PIN_HV)
    else $error("flags moved without elevated lsb level");
  one_quad_set_a: assert property (
    |(protect_flags & ~$past(protect_flags)) |-> $onehot(protect_flags ^ $past(protect_flags)))
    else $error("set touched more than one quadrant");
  clear_all_a: assert property (
    |($past(protect_flags) & ~protect_flags) |-> protect_flags == 4'h0)
    else $error("protection removed from only some quadrants");
  act_at_stop_a: assert property (
    $changed(protect_flags) |-> bus_idle)
    else $error("flags moved while a frame was running");
  ack_low_scl_a: assert property (
    $changed(dev_sda_oe) |-> !scl)
    else $error("device moved data while clock high");
  ack_width_a: assert property (
    $rose(dev_sda_oe) |=> ack_held ##[1:60] !dev_sda_oe)
    else $error("acknowledge slot of wrong length");
  pin_idle_a: assert property (
    $changed(lsb_code) |-> bus_idle)
    else $error("lsb pin level moved inside a frame");
  straps_a: assert property (
    $stable({mid, msb}))
    else $error("upper select pins moved");
endmodule : qwp_asserts
`default_nettype wire

/* testbench/quadrant_write_protect_ctrl_test.sv */
// self-checking bench: host controller driving the protected memory over the link
`default_nettype none
module quadrant_write_protect_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import qwp_pkg::*;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic page_select_state = 1'h0;
  logic [31:0] reg_rdata;
  logic [3:0] protect_flags;
  logic prog_req;
  logic [7:0] prog_addr;
  logic [7:0] prog_data;
  logic [3:0] prot = 4'h0;
  logic scl_d = 1'h1;
  logic sda_d = 1'h1;
  logic [3:0] bitn = 4'h9;
  logic [7:0] shf = 8'h00;
  logic [7:0] wire_ctrl = 8'h00;
  int bad_count = 0;
  int n_compared = 0;
  int n_prog = 0;

  always #10 sys_clk = ~sys_clk;

  qwp_link_if lif();
  // mid strap high so commands are seen to ignore it
  qwp_host #(.STRAP_MID(1'h1), .STRAP_MSB(1'h0)) qwp_host_i (.sys_clk(sys_clk),
    .reset(reset), .lif(lif.host), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  qwp_dev qwp_dev_i (.sys_clk(sys_clk), .reset(reset), .lif(lif.dev),
    .page_select_state(page_select_state), .protect_flags(protect_flags),
    .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data));
  qwp_asserts qwp_asserts_i (.sys_clk(sys_clk), .reset(reset), .scl(lif.scl),
    .sda(lif.sda), .dev_sda_oe(lif.dev_sda_oe), .lsb_code(lif.lsb_code),
    .mid(lif.mid), .msb(lif.msb), .protect_flags(protect_flags));
  ////////////////////////////////////////
  // wire monitor: first byte after each start, msb first, plus program pulses
  always @(posedge sys_clk) begin
    scl_d <= lif.scl;
    sda_d <= lif.sda;
    if (prog_req === 1'h1) n_prog <= n_prog + 1;
    if (lif.scl && scl_d && sda_d && !lif.sda) begin
      bitn <= 4'h0;
    end else if (lif.scl && !scl_d && bitn < 4'h8) begin
      shf <= {shf[6:0], lif.sda};
      if (bitn == 4'h7) wire_ctrl <= {shf[6:0], lif.sda};
      bitn <= bitn + 4'h1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask : rd
  ////////////////////////////////////////
  // acks {data, addr, ctrl}; a set or clear without elevated level dies at ctrl
  function automatic logic [2:0] exp_ack(input logic [1:0] k, input logic [1:0] q,
                                         input logic hv);
    if (k == KIND_QUERY) return {2'h0, !prot[q]};
    if (k == KIND_WRITE || hv) return 3'h7;
    return 3'h0;
  endfunction : exp_ack

  function automatic logic [7:0] exp_ctrl(input logic [1:0] k, input logic [1:0] q,
                                          input logic hv);
    logic [2:0] s;
    s = (q == 2'h0) ? 3'h1 : (q == 2'h1) ? 3'h4 : (q == 2'h2) ? 3'h5 : 3'h0;
    case (k)
      KIND_CLR: return 8'h66;
      KIND_QUERY: return {4'h6, s, 1'h1};
      KIND_WRITE: return {MEM_TYPE, 1'h0, 1'h1, hv, 1'h0};
      default: return {4'h6, s, 1'h0};
    endcase
  endfunction : exp_ctrl

  // one full frame through the host registers, then every effect compared
  task automatic op(input logic [1:0] k, input logic [1:0] q, input logic hv,
                    input logic [7:0] a, input logic [7:0] d);
    logic [31:0] st;
    logic [2:0] ack;
    logic wp;
    int i;
    int np;
    np = n_prog;
    ack = exp_ack(k, q, hv);
    wr(REG_XFER, {16'h0, d, a});
    wr(REG_CMD, {27'h0, hv, q, k});
    // page select is set just before the call, so read it only once it has landed
    wp = (k == KIND_WRITE) && !prot[{page_select_state, a[7]}];
    // writes while a frame runs must be dropped, or the frame and readback show it
    wr(REG_XFER, {16'h0, ~d, ~a});
    wr(REG_CMD, {27'h0, ~hv, ~q, ~k});
    for (i = 0; i < 2000; i++) begin
      rd(REG_STATUS, st);
      if (st[0] === 1'h0) break;
    end
    if (i == 2000) begin
      bad_count++;
      conclude();
    end
    // flags and program pulse land a few cycles after stop is seen
    repeat (8) @(posedge sys_clk);
    if (hv && k == KIND_SET) prot[q] = 1'h1;
    if (hv && k == KIND_CLR) prot = 4'h0;
    check(st[3:1], ack);
    check(wire_ctrl, exp_ctrl(k, q, hv));
    check({lif.scl, lif.sda}, 2'h3);
    check(protect_flags, prot);
    check(n_prog - np, wp);
    if (wp) check({prog_addr, prog_data}, {a, d});
    rd(REG_CMD, st);
    check(st, {27'h0, hv, q, k});
    rd(REG_XFER, st);
    check(st, {16'h0, d, a});
  endtask : op
  ////////////////////////////////////////
  initial begin
    logic [31:0] v;
    int j;
    void'($urandom(85));
    repeat (16) @(posedge sys_clk);
    reset <= 1'h0;
    repeat (4) @(posedge sys_clk);
    rd(8'h0C, v);
    check(v, 32'h0); // unmapped place reads zero
    // each quadrant: free, protected, then queried at low lsb level (even quadrants) or elevated (odd quadrants)
    for (j = 0; j < 4; j++) begin
      op(KIND_QUERY, j[1:0], 1'h0, 8'h00, 8'h00);
      op(KIND_SET, j[1:0], 1'h1, 8'h00, 8'hFF);
      op(KIND_QUERY, j[1:0], j[0], 8'hFF, 8'h00);
    end
    op(KIND_WRITE, 2'h0, 1'h0, 8'h81, 8'h5A);
    op(KIND_CLR, 2'h0, 1'h0, 8'h00, 8'h00);
    op(KIND_CLR, 2'h1, 1'h1, 8'h12, 8'h34);
    op(KIND_SET, 2'h2, 1'h0, 8'h00, 8'h00);
    op(KIND_WRITE, 2'h0, 1'h1, 8'h7F, 8'hA5);
    // random mix of all four kinds, pages and levels
    for (j = 0; j < 16; j++) begin
      page_select_state <= 1'($urandom);
      op(2'($urandom), 2'($urandom), 1'($urandom), 8'($urandom), 8'($urandom));
    end
    conclude();
  end
endmodule : quadrant_write_protect_ctrl_test
`default_nettype wire
